// ---- rtl/ddr_flash_write_and_page_latency.sv ----
/*
  Device-side transaction logic of a DDR serial-parallel flash: command/
  address capture, DDR write words, linear reads with page-crossing wait
  words, read strobe, and tracking of the write-buffer program sequence.
  Assumes the link clock stands still while select is high, and the core
  clock keeps running; configuration arrives on plain core-side inputs.
*/
`timescale 1ns/1ps
`include "ddr_flash_params.svh"

module ddr_flash_write_and_page_latency
  import ddr_flash_pkg::*;
#(
  parameter int MEM_AW = 10
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        linkClk,
  input  wire logic        phaseShiftedClock,
  input  wire logic        csN,
  input  wire logic [7:0]  dqIn,
  output logic      [7:0]  dqOut,
  output logic             dqOeN,
  output logic             readStrobeLineOut,
  output logic             readStrobeLineOeN,
  input  wire logic        cfgLoad,
  input  wire logic [3:0]  cfgLatencyCode,
  input  wire logic        cfgStrobeOption,
  output logic             cfgBusy,
  output cfg_s             configurationRegister,
  output logic             frameDone,
  output frame_s           frameInfo,
  output logic             progConfirm,
  output logic [14:0]      progSector,
  output logic [16:0]      progWords,
  output logic             seqError
);

  // ========================================================================
  // Link side: frame state on the falling edge
  logic        frameRst;
  logic        linkClkN;
  logic [7:0]  riseByte_q, riseByte_d;
  logic [15:0] word;
  logic [5:0]  cyc_q, cyc_d;
  logic [31:0] ca_q, ca_d;
  ca_s         caNow;
  logic        rdMode_q, rdMode_d, wrMode_q, wrMode_d, linear_q, linear_d;
  logic [31:0] rdAddr_q, rdAddr_d, wrAddr_q, wrAddr_d;
  logic [4:0]  firstLeft_q, firstLeft_d, gap_q, gap_d, lat;
  logic        issue, rdValid_q, rdValid_d;
  frame_s      xFrame_q, xFrame_d;
  logic [15:0] memRdData;
  cfg_s        cfgLink_q, cfgLink_d;
  logic        cfgAck_q, cfgAck_d, reqLevel;
  cfg_s        cfgReg_q, cfgReg_d;
  logic        cfgReq_q, cfgReq_d, ackLevel;

  // Select high ends the frame even though no further link edge arrives
  assign frameRst = csN | ~nrst;
  assign linkClkN = ~linkClk;
  assign word     = {riseByte_q, dqIn};
  assign lat      = latencyClocks(cfgLink_q.latencyCode);

  always_comb begin
    cyc_d       = (cyc_q == 6'h3F) ? cyc_q : cyc_q + 6'h01;
    ca_d        = {ca_q[15:0], word};
    caNow       = decodeCa({ca_q, word});
    rdMode_d    = rdMode_q;
    wrMode_d    = wrMode_q;
    linear_d    = linear_q;
    rdAddr_d    = rdAddr_q;
    wrAddr_d    = wrAddr_q;
    firstLeft_d = firstLeft_q;
    gap_d       = gap_q;
    issue       = 1'b0;
    if (cyc_q == `CA_LAST_CYCLE) begin
      rdMode_d = caNow.isRead;
      wrMode_d = ~caNow.isRead;
      // Writes are always linear whatever the burst bit says
      linear_d = ~caNow.isRead | caNow.linear;
      rdAddr_d = caNow.addr;
      wrAddr_d = caNow.addr;
      if (caNow.linear) begin
        firstLeft_d = `PAGE_WORDS - {2'h0, caNow.addr[2:0]};
        gap_d       = pageGap(caNow.addr[2:0], lat);
      end else begin
        firstLeft_d = 5'h00;
        gap_d       = 5'h00;
      end
    end
    // Read issued one falling edge ahead of the clock that shows it
    if (rdMode_q && (cyc_q >= {1'b0, lat} + 6'h01)) begin
      if (firstLeft_q != 5'h00) begin
        issue       = 1'b1;
        firstLeft_d = firstLeft_q - 5'h01;
      end else if (gap_q != 5'h00) begin
        gap_d = gap_q - 5'h01;
      end else begin
        issue = 1'b1;
      end
    end
    if (issue) begin
      rdAddr_d = linear_q ? rdAddr_q + 32'h1
                          : {rdAddr_q[31:4], rdAddr_q[3:0] + 4'h1};
    end
    rdValid_d = issue;
    if (wrMode_q) begin
      wrAddr_d = wrAddr_q + 32'h1;
    end
  end

  always_ff @(negedge linkClk or posedge frameRst) begin
    if (frameRst) begin
      cyc_q       <= 6'h00;
      ca_q        <= 32'h0;
      rdMode_q    <= 1'b0;
      wrMode_q    <= 1'b0;
      linear_q    <= 1'b0;
      rdAddr_q    <= 32'h0;
      wrAddr_q    <= 32'h0;
      firstLeft_q <= 5'h00;
      gap_q       <= 5'h00;
      rdValid_q   <= 1'b0;
    end else begin
      cyc_q       <= cyc_d;
      ca_q        <= ca_d;
      rdMode_q    <= rdMode_d;
      wrMode_q    <= wrMode_d;
      linear_q    <= linear_d;
      rdAddr_q    <= rdAddr_d;
      wrAddr_q    <= wrAddr_d;
      firstLeft_q <= firstLeft_d;
      gap_q       <= gap_d;
      rdValid_q   <= rdValid_d;
    end
  end

  // Frame summary survives select high so the core can take it over
  always_comb begin
    xFrame_d = xFrame_q;
    if (cyc_q == 6'h00) begin
      xFrame_d = '0;
    end
    if (cyc_q == `CA_LAST_CYCLE) begin
      xFrame_d.complete = 1'b1;
      xFrame_d.isRead   = caNow.isRead;
      xFrame_d.addr     = caNow.addr;
    end
    if (wrMode_q) begin
      if (xFrame_q.words == 16'h0000) begin
        xFrame_d.firstData = word;
      end
      xFrame_d.words = xFrame_q.words + 16'h0001;
    end
  end

  always_ff @(negedge linkClk or negedge nrst) begin
    if (!nrst) begin
      xFrame_q <= '0;
    end else begin
      xFrame_q <= xFrame_d;
    end
  end

  flash_word_mem #(
    .DATA_W (16),
    .ADDR_W (MEM_AW)
  ) u_mem (
    .clk    (linkClkN),
    .nrst   (nrst),
    .we     (wrMode_q),
    .wrAddr (wrAddr_q[MEM_AW-1:0]),
    .wrData (word),
    .re     (issue),
    .rdAddr (rdAddr_q[MEM_AW-1:0]),
    .rdData (memRdData)
  );

  // ========================================================================
  // Link side: rising edge capture and read output
  logic [15:0] outWord_q, outWord_d;
  logic        outValid_q, outValid_d, outDrive_q, outDrive_d, strobeClk;

  always_comb begin
    riseByte_d = dqIn;
    outWord_d  = memRdData;
    outValid_d = rdValid_q;
    outDrive_d = rdMode_q;
  end

  always_ff @(posedge linkClk or posedge frameRst) begin
    if (frameRst) begin
      riseByte_q <= 8'h00;
      outWord_q  <= 16'h0000;
      outValid_q <= 1'b0;
      outDrive_q <= 1'b0;
    end else begin
      riseByte_q <= riseByte_d;
      outWord_q  <= outWord_d;
      outValid_q <= outValid_d;
      outDrive_q <= outDrive_d;
    end
  end

  // Only the true phase-shifted clock is used; complements are not needed
  assign strobeClk = cfgLink_q.strobeOption ? phaseShiftedClock
                                            : linkClk;
  assign dqOut     = linkClk ? outWord_q[15:8] : outWord_q[7:0];
  assign dqOeN     = csN | ~outDrive_q;
  // Strobe owned for the whole frame: low on writes, toggling on reads
  assign readStrobeLineOeN = csN;
  assign readStrobeLineOut = outValid_q & strobeClk;

  // Configuration copy; a new value lands at a frame's first link edges
  level_sync3 #(.RESET_VAL(1'b0)) u_reqSync (
    .clk  (linkClk),
    .nrst (nrst),
    .d    (cfgReq_q),
    .q    (reqLevel)
  );

  always_comb begin
    cfgLink_d = cfgLink_q;
    cfgAck_d  = cfgAck_q;
    if (reqLevel != cfgAck_q) begin
      cfgLink_d = cfgReg_q;
      cfgAck_d  = reqLevel;
    end
  end

  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      cfgLink_q <= '{strobeOption: `STROBE_OPT_RST,
                     latencyCode: `LAT_CODE_RST};
      cfgAck_q  <= 1'b0;
    end else begin
      cfgLink_q <= cfgLink_d;
      cfgAck_q  <= cfgAck_d;
    end
  end

  // ========================================================================
  // Core side: configuration register with handshake to the link

  level_sync3 #(.RESET_VAL(1'b0)) u_ackSync (
    .clk  (clk),
    .nrst (nrst),
    .d    (cfgAck_q),
    .q    (ackLevel)
  );

  assign cfgBusy = cfgReq_q != ackLevel;

  always_comb begin
    cfgReg_d = cfgReg_q;
    cfgReq_d = cfgReq_q;
    // Reserved codes are dropped so the link never sees them
    if (cfgLoad && !cfgBusy && cfgLatencyCode <= `LAT_CODE_MAX) begin
      cfgReg_d.latencyCode  = cfgLatencyCode;
      cfgReg_d.strobeOption = cfgStrobeOption;
      cfgReq_d              = ~cfgReq_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgReg_q <= '{strobeOption: `STROBE_OPT_RST,
                    latencyCode: `LAT_CODE_RST};
      cfgReq_q <= 1'b0;
    end else begin
      cfgReg_q <= cfgReg_d;
      cfgReq_q <= cfgReq_d;
    end
  end

  assign configurationRegister = cfgReg_q;

  // ========================================================================
  // Core side: frame hand-over and buffer-program sequence tracking
  logic        csLevel, csPrev_q, frameEnd;
  frame_s      frameInfo_q, frameInfo_d, f;
  logic        frameDone_q;
  seq_e        seq_q, seq_d;
  logic [14:0] sector_q, sector_d, fSector;
  logic [16:0] remain_q, remain_d, total_q, total_d;
  logic        progConfirm_q, progConfirm_d, seqError_q, seqError_d;

  level_sync3 #(.RESET_VAL(1'b1)) u_csSync (
    .clk  (clk),
    .nrst (nrst),
    .d    (csN),
    .q    (csLevel)
  );

  // Link is stopped once select is high, so its summary is stable here
  assign frameEnd = csLevel & ~csPrev_q;
  assign f        = xFrame_q;
  assign fSector  = 15'(f.addr >> `SECTOR_SHIFT);

  always_comb begin
    frameInfo_d   = frameEnd ? f : frameInfo_q;
    seq_d         = seq_q;
    sector_d      = sector_q;
    remain_d      = remain_q;
    total_d       = total_q;
    progConfirm_d = 1'b0;
    seqError_d    = 1'b0;
    if (frameEnd && f.complete && !f.isRead) begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (f.addr == `UNLOCK_ADDR && f.firstData == `UNLOCK_DATA) begin
            seq_d = SEQ_UNLOCKED;
          end
        end
        SEQ_UNLOCKED: begin
          seq_d    = (f.firstData == `BUF_PROG_CMD) ? SEQ_COUNT
                                                    : SEQ_IDLE;
          sector_d = fSector;
        end
        SEQ_COUNT: begin
          remain_d   = {1'b0, f.firstData} + 17'h00001;
          total_d    = {1'b0, f.firstData} + 17'h00001;
          seq_d      = (fSector == sector_q) ? SEQ_DATA : SEQ_IDLE;
          seqError_d = fSector != sector_q;
        end
        SEQ_DATA: begin
          if ({1'b0, f.words} > remain_q) begin
            seq_d      = SEQ_IDLE;
            seqError_d = 1'b1;
          end else begin
            remain_d = remain_q - {1'b0, f.words};
            if (remain_q == {1'b0, f.words}) begin
              seq_d = SEQ_CONFIRM;
            end
          end
        end
        SEQ_CONFIRM: begin
          seq_d = SEQ_IDLE;
          if (f.firstData == `BUF_PROG_CONFIRM && fSector == sector_q) begin
            progConfirm_d = 1'b1;
          end else begin
            seqError_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      csPrev_q      <= 1'b1;
      frameInfo_q   <= '0;
      frameDone_q   <= 1'b0;
      seq_q         <= SEQ_IDLE;
      sector_q      <= 15'h0000;
      remain_q      <= 17'h00000;
      total_q       <= 17'h00000;
      progConfirm_q <= 1'b0;
      seqError_q    <= 1'b0;
    end else begin
      csPrev_q      <= csLevel;
      frameInfo_q   <= frameInfo_d;
      frameDone_q   <= frameEnd;
      seq_q         <= seq_d;
      sector_q      <= sector_d;
      remain_q      <= remain_d;
      total_q       <= total_d;
      progConfirm_q <= progConfirm_d;
      seqError_q    <= seqError_d;
    end
  end

  assign frameInfo   = frameInfo_q;
  assign frameDone   = frameDone_q;
  assign progConfirm = progConfirm_q;
  assign progSector  = sector_q;
  assign progWords   = total_q;
  assign seqError    = seqError_q;

endmodule // ddr_flash_write_and_page_latency

// ---- rtl/ddr_flash_params.svh ----
/*
  Constants of the DDR flash transaction block: command/address layout,
  page geometry, latency coding and command-sequence values.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef DDR_FLASH_PARAMS_SVH
`define DDR_FLASH_PARAMS_SVH

// ==========================================================================
// Command/address word layout (48 bits, three link clocks)
`define CA_READ_BIT      47
`define CA_SPACE_BIT     46
`define CA_BURST_BIT     45
`define CA_UPPER_HI      44
`define CA_UPPER_LO      16
`define CA_LOWER_HI      2
`define CA_LAST_CYCLE    6'h02

// ==========================================================================
// Page geometry in words
`define PAGE_WORDS       5'h10
`define SUBPAGE_WORDS    6'h08

// ==========================================================================
// Latency coding in the configuration register
`define LAT_FIELD_HI     7
`define LAT_FIELD_LO     4
`define LAT_BASE         5'h05
`define LAT_CODE_MAX     4'hB
`define LAT_CODE_RST     4'hB
`define STROBE_OPT_RST   1'h0

// ==========================================================================
// Command-sequence values
`define UNLOCK_ADDR      32'h0000_02AA
`define UNLOCK_DATA      16'h0055
`define BUF_PROG_CMD     16'h0025
`define BUF_PROG_CONFIRM 16'h0029
`define SECTOR_SHIFT     17

`endif

// ---- rtl/ddr_flash_pkg.sv ----
/*
  Types and shared helpers of the DDR flash transaction block.
  Assumes the constants header sits beside it on the include path.
*/
`include "ddr_flash_params.svh"

package ddr_flash_pkg;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic        isRead;
    logic        space;
    logic        linear;
    logic [31:0] addr;
  } ca_s;

  typedef struct packed {
    logic        complete;
    logic        isRead;
    logic [31:0] addr;
    logic [15:0] firstData;
    logic [15:0] words;
  } frame_s;

  typedef struct packed {
    logic       strobeOption;
    logic [3:0] latencyCode;
  } cfg_s;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_UNLOCKED,
    SEQ_COUNT,
    SEQ_DATA,
    SEQ_CONFIRM
  } seq_e;

  // ========================================================================
  // Helpers
  function automatic ca_s decodeCa(input logic [47:0] raw);
    ca_s c;
    c.isRead = raw[`CA_READ_BIT];
    c.space  = raw[`CA_SPACE_BIT];
    c.linear = raw[`CA_BURST_BIT];
    c.addr   = {raw[`CA_UPPER_HI:`CA_UPPER_LO], raw[`CA_LOWER_HI:0]};
    return c;
  endfunction

  function automatic logic [4:0] latencyClocks(input logic [3:0] code);
    return {1'b0, code} + `LAT_BASE;
  endfunction

  // Extra wait words at the first page crossing; sum form keeps it unsigned
  function automatic logic [4:0] pageGap(input logic [2:0] sub,
                                         input logic [4:0] lat);
    logic [5:0] sum;
    sum = {3'h0, sub} + {1'b0, lat};
    if (sum > {1'b0, `PAGE_WORDS})
      return 5'(sum - {1'b0, `PAGE_WORDS});
    return 5'h00;
  endfunction

endpackage

// ---- rtl/level_sync3.sv ----
/*
  Three-stage level synchroniser; the output follows once stages two and
  three agree. Assumes the input is a level held for several clocks.
*/
`timescale 1ns/1ps

module level_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic d,
  output logic      q
);

  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      lvl_q <= RESET_VAL;
    end else begin
      s1_q  <= d;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign q = lvl_q;

endmodule // level_sync3

// ---- rtl/flash_word_mem.sv ----
/*
  Small word array with one write port and one registered read port.
  Assumes a single clock; unwritten words read back undefined.
*/
`timescale 1ns/1ps

module flash_word_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 10
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              re,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rdData_q, rdData_d;

  always_comb begin
    rdData_d = re ? mem[rdAddr] : rdData_q;
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;

endmodule // flash_word_mem

// ---- testbench/ddr_flash_asserts.sv ----
/*
  Checker of the DDR flash block, bound to its top module.
  Assumes nrst resets both the core and the link domain.
*/
`timescale 1ns/1ps

module ddr_flash_asserts
  import ddr_flash_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       linkClk,
  input wire logic       csN,
  input wire logic       dqOeN,
  input wire logic       readStrobeLineOut,
  input wire logic       readStrobeLineOeN,
  input wire logic       cfgLoad,
  input wire logic [3:0] cfgLatencyCode,
  input wire logic       cfgStrobeOption,
  input wire logic       cfgBusy,
  input wire cfg_s       configurationRegister,
  input wire logic       frameDone,
  input wire logic       progConfirm,
  input wire logic       seqError
);
  // ==========
  // Link cycles seen in a frame; select high clears at once
  logic [5:0] linkCnt_q;
  logic [5:0] linkCnt_d;

  always_comb begin
    linkCnt_d = (linkCnt_q == 6'h3F) ? linkCnt_q : linkCnt_q + 6'h01;
  end

  always_ff @(posedge linkClk or posedge csN or negedge nrst) begin
    if (!nrst) linkCnt_q <= 6'h00;
    else if (csN) linkCnt_q <= 6'h00;
    else linkCnt_q <= linkCnt_d;
  end

  // ==========
  // Link side
  a_ca_not_driven:
  assert property (@(negedge linkClk) disable iff (!nrst)
    (!csN && linkCnt_q <= 6'h03) |-> dqOeN) else $error("dq driven in CA");
  a_write_strobe_low:
  assert property (@(negedge linkClk) disable iff (!nrst)
    (!csN && dqOeN) |-> !readStrobeLineOut) else $error("strobe high");
  a_strobe_oe_frame:
  assert property (@(posedge clk) disable iff (!nrst)
    readStrobeLineOeN == csN) else $error("strobe enable wrong");
  a_dq_release:
  assert property (@(posedge clk) disable iff (!nrst)
    csN |-> dqOeN) else $error("dq driven while idle");

  // ==========
  // Core side
  a_done_pulse:
  assert property (@(posedge clk) disable iff (!nrst)
    frameDone |=> !frameDone) else $error("done too long");
  a_done_after_end:
  assert property (@(posedge clk) disable iff (!nrst)
    frameDone |-> csN && $past(csN, 2)) else $error("done early");
  a_cfg_load:
  assert property (@(posedge clk) disable iff (!nrst)
    (cfgLoad && !cfgBusy && cfgLatencyCode <= 4'hB) |=> cfgBusy &&
    configurationRegister == {$past(cfgStrobeOption), $past(cfgLatencyCode)})
    else $error("load not taken");
  a_cfg_reserved:
  assert property (@(posedge clk) disable iff (!nrst)
    (cfgLoad && cfgLatencyCode > 4'hB) |=> $stable(configurationRegister))
    else $error("reserved code taken");
  a_busy_cause:
  assert property (@(posedge clk) disable iff (!nrst)
    $rose(cfgBusy) |-> $past(cfgLoad)) else $error("busy without load");
  a_confirm_pulse:
  assert property (@(posedge clk) disable iff (!nrst)
    progConfirm |-> !seqError ##1 !progConfirm) else $error("bad confirm");
endmodule // ddr_flash_asserts

bind ddr_flash_write_and_page_latency ddr_flash_asserts ddr_flash_asserts_i (
  .clk(clk), .nrst(nrst), .linkClk(linkClk), .csN(csN), .dqOeN(dqOeN),
  .readStrobeLineOut(readStrobeLineOut),
  .readStrobeLineOeN(readStrobeLineOeN), .cfgLoad(cfgLoad),
  .cfgLatencyCode(cfgLatencyCode), .cfgStrobeOption(cfgStrobeOption),
  .cfgBusy(cfgBusy), .configurationRegister(configurationRegister),
  .frameDone(frameDone), .progConfirm(progConfirm), .seqError(seqError)
);

// ---- testbench/host_model.sv ----
/*
  Host controller model: link clock, select and byte bus of one frame.
  Assumes the bench fills wq before a write and reads rq, sq after.
*/
`timescale 1ns/1ps

module host_model (
  output logic            linkClk,
  output logic            phaseShiftedClock,
  output logic            csN,
  output logic      [7:0] dqIn,
  input  wire logic [7:0] dqOut,
  input  wire logic       dqOeN,
  input  wire logic       readStrobeLineOut,
  input  wire logic       readStrobeLineOeN
);
  logic [7:0]  hDq;
  logic        hOe;
  logic [15:0] wq[$];
  logic [15:0] rq[$];
  logic        sq[$];

  // Nobody driving: wire shows the inverse of the host's last byte
  assign dqIn = hOe ? hDq : (dqOeN ? ~hDq : dqOut);

  // Complement clocks are left out, which the strobe mode allows
  always @(linkClk) phaseShiftedClock <= #3.75 linkClk;

  initial begin
    linkClk = 1'b0;
    phaseShiftedClock = 1'b0;
    // Low at first so that reset gives the frame logic a clean edge
    csN = 1'b0;
    hDq = 8'h00;
    hOe = 1'b0;
    #2 csN = 1'b1;
  end

  // One link cycle: high byte at the rise, low byte at the fall
  task automatic cyc(input logic [15:0] w);
    logic [15:0] r;
    logic        s;
    hDq = w[15:8];
    #3.75 linkClk = 1'b1;
    #5 r[15:8] = dqIn;
    s = readStrobeLineOut;
    hDq = w[7:0];
    #2.5 linkClk = 1'b0;
    #3.5 r[7:0] = dqIn;
    #0.25;
    rq.push_back(r);
    sq.push_back(s);
  endtask

  task automatic frame(input logic [47:0] ca, input int n, input logic rd,
                       input logic half);
    rq.delete();
    sq.delete();
    hOe = 1'b1;
    csN = 1'b0;
    for (int i = 2; i >= 0; i--) cyc(ca[16*i +: 16]);
    hOe = !rd;
    for (int i = 0; i < n; i++) cyc(rd ? 16'h0000 : wq[i]);
    // A paused clock must not keep the cut frame open
    if (half) #37.5;
    csN = 1'b1;
    hOe = 1'b0;
    #100;
  endtask
endmodule // host_model

// ---- testbench/test_ddr_flash_write_and_page_latency.sv ----
/*
  Self-checking bench of the DDR flash block with the host model.
  Assumes the block's package and header are compiled first.
*/
`timescale 1ns/1ps

module test_ddr_flash_write_and_page_latency;
  import ddr_flash_pkg::*;

  typedef struct {
    logic [31:0] addr;
    logic [3:0]  code;
    logic        opt;
    int          gap;
  } row_s;

  localparam logic [15:0] BASE = 16'h9C30;
  localparam logic [31:0] SECT = 32'h0002_0300;

  logic        clk, nrst, cfgLoad, cfgStrobeOption, linkClk;
  logic        phaseShiftedClock, csN, dqOeN, cfgBusy, frameDone;
  logic        readStrobeLineOut, readStrobeLineOeN, progConfirm, seqError;
  logic [3:0]  cfgLatencyCode;
  logic [7:0]  dqIn, dqOut;
  logic [14:0] progSector, confSector;
  logic [16:0] progWords, confWords;
  cfg_s        configurationRegister;
  frame_s      frameInfo, lastInfo;
  int          mismatches, checks, cycles, doneCnt, confCnt, errCnt;

  // Start address, latency code, strobe mode, wait words at the crossing
  row_s rows[8] = '{'{32'h1, 4'hB, 1'b0, 1}, '{32'h0, 4'hB, 1'b0, 0},
    '{32'h7, 4'hB, 1'b0, 7}, '{32'h8, 4'hB, 1'b0, 0},
    '{32'h9, 4'hB, 1'b0, 1}, '{32'h7, 4'h7, 1'b0, 3},
    '{32'hF, 4'h7, 1'b1, 3}, '{32'h7, 4'h0, 1'b0, 0}};

  ddr_flash_write_and_page_latency ddr_flash_write_and_page_latency_i (
    .clk(clk), .nrst(nrst), .linkClk(linkClk),
    .phaseShiftedClock(phaseShiftedClock), .csN(csN), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN), .readStrobeLineOut(readStrobeLineOut),
    .readStrobeLineOeN(readStrobeLineOeN), .cfgLoad(cfgLoad),
    .cfgLatencyCode(cfgLatencyCode), .cfgStrobeOption(cfgStrobeOption),
    .cfgBusy(cfgBusy), .configurationRegister(configurationRegister),
    .frameDone(frameDone), .frameInfo(frameInfo),
    .progConfirm(progConfirm), .progSector(progSector),
    .progWords(progWords), .seqError(seqError));

  host_model host_model_i (
    .linkClk(linkClk), .phaseShiftedClock(phaseShiftedClock), .csN(csN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .readStrobeLineOut(readStrobeLineOut),
    .readStrobeLineOeN(readStrobeLineOeN));

  always #5 clk = ~clk;

  // ==========
  // Pulse capture and hang guard
  always @(posedge clk) begin
    cycles++;
    if (frameDone === 1'b1) begin
      doneCnt++;
      lastInfo = frameInfo;
    end
    if (progConfirm === 1'b1) begin
      confCnt++;
      confWords = progWords;
      confSector = progSector;
    end
    if (seqError === 1'b1) errCnt++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==========
  // Tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [79:0] e,
                     input logic [79:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  function automatic logic [47:0] mkCa(input logic rd, input logic lin,
                                       input logic [31:0] a);
    return {rd, 1'b0, lin, a[31:3], 13'h0000, a[2:0]};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [15:0] d,
                    input int n, input logic lin, input logic half);
    int c;
    c = doneCnt;
    host_model_i.wq.delete();
    for (int i = 0; i < n; i++) host_model_i.wq.push_back(d + 16'(i));
    host_model_i.frame(mkCa(1'b0, lin, a), n, 1'b0, half);
    chk("frame done", 80'h1, 80'(doneCnt - c));
    chk("address", a, lastInfo.addr);
    chk("first word", d, lastInfo.firstData);
    chk("words", 80'(n), lastInfo.words);
    chk("is read", 1'b0, lastInfo.isRead);
  endtask

  task automatic setCfg(input logic [3:0] c, input logic o, input cfg_s e);
    @(posedge clk);
    #1;
    cfgLatencyCode = c;
    cfgStrobeOption = o;
    cfgLoad = 1'b1;
    @(posedge clk);
    #1;
    cfgLoad = 1'b0;
    @(posedge clk);
    #1;
    chk("config", e, configurationRegister);
    // The link copies the setting only while a frame runs
    for (int t = 0; t < 4 && cfgBusy !== 1'b0; t++)
      host_model_i.frame(mkCa(1'b1, 1'b1, 32'h0), 4, 1'b1, 1'b0);
    chk("busy", 1'b0, cfgBusy);
  endtask

  task automatic rdRow(input row_s r);
    int          l;
    int          w;
    int          b;
    logic [31:0] ea;
    l = int'(r.code) + 5;
    w = 16 - int'(r.addr[2:0]);
    host_model_i.frame(mkCa(1'b1, 1'b1, r.addr), l + w + r.gap + 1, 1'b1,
                       1'b0);
    chk("latency strobe", 1'b0, host_model_i.sq[l+1]);
    for (int k = 0; k < w + r.gap + 2; k++) begin
      b = l + 2 + k;
      ea = r.addr + 32'((k < w) ? k : k - r.gap);
      if (k >= w && k < w + r.gap) begin
        chk("gap strobe", 1'b0, host_model_i.sq[b]);
      end else begin
        chk("strobe", 1'b1, host_model_i.sq[b]);
        chk("data", BASE + ea[15:0], host_model_i.rq[b]);
      end
    end
    $display("read at %0h done", r.addr);
  endtask

  // ==========
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b1;
    cfgLoad = 1'b0;
    cfgLatencyCode = 4'h0;
    cfgStrobeOption = 1'b0;
    #1 nrst = 1'b0;
    repeat (6) @(posedge clk);
    chk("config reset", 5'h0B, configurationRegister);
    #1;
    nrst = 1'b1;
    repeat (5) @(posedge clk);
    wr(32'h2AA, 16'h0055, 1, 1'b1, 1'b0);
    wr(SECT, 16'h0025, 1, 1'b0, 1'b0);
    wr(SECT, 16'h0019, 1, 1'b1, 1'b0);
    wr(32'h0, BASE, 26, 1'b0, 1'b1);
    wr(SECT, 16'h0029, 1, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk("confirms", 80'h1, 80'(confCnt));
    chk("prog words", 17'h0001A, confWords);
    chk("prog sector", 15'h0001, confSector);
    chk("seq errors", 80'h0, 80'(errCnt));
    $display("buffer program done");
    foreach (rows[i]) begin
      if (configurationRegister !== {rows[i].opt, rows[i].code})
        setCfg(rows[i].code, rows[i].opt, {rows[i].opt, rows[i].code});
      rdRow(rows[i]);
    end
    setCfg(4'hC, 1'b1, configurationRegister);
    $display("reserved code done");
    wr(32'h2AA, 16'h0055, 1, 1'b1, 1'b0);
    wr(SECT, 16'h0025, 1, 1'b1, 1'b0);
    wr(SECT + 32'h0002_0000, 16'h0003, 1, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk("seq errors", 80'h1, 80'(errCnt));
    $display("broken sequence done");
    @(posedge clk);
    #1;
    nrst = 1'b0;
    #1;
    chk("config reset", 5'h0B, configurationRegister);
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk);
    chk("config after reset", 5'h0B, configurationRegister);
    $display("reset done");
    give_verdict();
  end
endmodule // test_ddr_flash_write_and_page_latency
